// file: hw/uenm_ep0_ctrl.sv
// endpoint-0 control/status and nak interrupt masking with avalon-mm slave
// assumes the packet engine shares sys_clk and drives one-cycle event pulses
`timescale 1ns/100ps
module uenm_ep0_ctrl
    import uenm_pkg::*;
(
    // clock and reset
    input  wire logic             sys_clk,
    input  wire logic             nrst,
    // avalon-mm slave
    input  wire logic [4:0]       avs_address,
    input  wire logic             avs_read,
    input  wire logic             avs_write,
    input  wire logic [31:0]      avs_writedata,
    input  wire logic [3:0]       avs_byteenable,
    output logic [31:0]           avs_readdata,
    output logic                  avs_waitrequest,
    // packet engine events
    input  wire uenm_link_ev_type link_ev,
    // to packet engine and interrupt controller
    output logic                  nak_irq,
    output logic [6:0]            ep0_max_pkt,
    output logic                  zero_len_send_pending,
    output logic                  ep0_wr_allow,
    output logic                  ep0_toggle
);

    // ------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------
    logic rst_s1_q;
    logic rst_n;

    // async assert, two-flop release keeps recovery clean
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            rst_s1_q <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n    <= rst_s1_q;
        end
    end

    // ------------------------------------------------------------
    // bus slave
    // ------------------------------------------------------------
    logic        wait_q;
    logic [31:0] rdata_q;
    logic        wr_take;
    logic        lo_byte;
    logic [7:0]  nak_flags;
    logic [7:0]  nak_mask_q;
    logic [6:0]  max_pkt_q;
    logic        zlp_q;
    logic        dset_q;
    logic        lock_q;
    logic        allow_q;
    logic [1:0]  toggle_q;
    uenm_ep0_state_type state_q;
    logic        nak_irq_q;
    logic [31:0] rd_mux;

    // a write lands at the edge where the master sees waitrequest low
    assign wr_take = avs_write && !wait_q;
    assign lo_byte = avs_byteenable[0];

    // read mux; unmapped offsets return zero
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (avs_address)
            OFS_NAK_FLAGS: begin
                rd_mux[7:0] = nak_flags;
            end
            OFS_NAK_MASK: begin
                rd_mux[7:0] = nak_mask_q;
            end
            OFS_EP0_PKTSIZE: begin
                rd_mux[ZLP_PEND_BIT]       = zlp_q;
                rd_mux[BUF_VALID_BIT]      = dset_q;
                rd_mux[MAXPKT_HI:0]        = max_pkt_q;
            end
            OFS_EP0_STATE: begin
                rd_mux[WR_LOCK_BIT]        = lock_q;
                rd_mux[TOGGLE_LO+:2]       = toggle_q;
                rd_mux[STATE_LO+:3]        = state_q;
            end
            default: begin
                rd_mux = 32'h0000_0000;
            end
        endcase
    end

    // one wait cycle per request, then a single ready cycle
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            wait_q  <= 1'b1;
            rdata_q <= 32'h0000_0000;
        end else if ((avs_read || avs_write) && wait_q) begin
            wait_q  <= 1'b0;
            rdata_q <= rd_mux;
        end else begin
            wait_q  <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // nak flags, mask and interrupt
    // ------------------------------------------------------------
    logic [7:0] flag_clr;
    logic       cmd_wr;

    assign flag_clr = (wr_take && lo_byte && avs_address == OFS_NAK_FLAGS)
                    ? avs_writedata[7:0] : 8'h00;
    assign cmd_wr   = wr_take && lo_byte && avs_address == OFS_COMMAND;

    uenm_flag_bank u_flags (
        .clk      (sys_clk),
        .rst_n    (rst_n),
        .set_bits (link_ev.nak_ep),
        .clr_bits (flag_clr),
        .flags    (nak_flags)
    );

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            nak_mask_q <= NAK_MASK_RST;
        end else if (wr_take && lo_byte && avs_address == OFS_NAK_MASK) begin
            nak_mask_q <= {avs_writedata[7:1], 1'b0};
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            nak_irq_q <= 1'b0;
        end else begin
            nak_irq_q <= |(nak_flags & ~nak_mask_q);
        end
    end

    // ------------------------------------------------------------
    // endpoint-0 packet size register
    // ------------------------------------------------------------
    // max packet size field
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            max_pkt_q <= MAXPKT_RST;
        end else if (wr_take && lo_byte && avs_address == OFS_EP0_PKTSIZE) begin
            max_pkt_q <= avs_writedata[MAXPKT_HI:0];
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            zlp_q <= 1'b0;
        end else if (cmd_wr && avs_writedata[7:0] == CMD_ZERO_LEN_SEND) begin
            zlp_q <= 1'b1;
        end else if (link_ev.zlp_sent) begin
            zlp_q <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            dset_q <= 1'b0;
        end else if (link_ev.setup_token || link_ev.buf_drain) begin
            dset_q <= 1'b0;
        end else if (link_ev.buf_fill) begin
            dset_q <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // endpoint-0 status word
    // ------------------------------------------------------------
    // setup lock; a setup in the ack cycle keeps it set
    // allow_q is a flop of its own so the write-allow pin needs no gate
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            lock_q  <= 1'b0;
            allow_q <= 1'b1;
        end else if (link_ev.setup_token) begin
            lock_q  <= 1'b1;
            allow_q <= 1'b0;
        end else if (cmd_wr && avs_writedata[7:0] == CMD_SETUP_ACK) begin
            lock_q  <= 1'b0;
            allow_q <= 1'b1;
        end
    end

    // toggle: setup restarts at data0, each data phase flips it
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            toggle_q <= TOGGLE_RST;
        end else if (link_ev.setup_token) begin
            toggle_q <= TOGGLE_RST;
        end else if (link_ev.data_ack) begin
            toggle_q <= {1'b0, ~toggle_q[0]};   // reserved codes never produced
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= EP0_READY;
        end else if (link_ev.setup_token) begin
            state_q <= EP0_READY;
        end else if (link_ev.over_len) begin
            state_q <= EP0_STALL;
        end else if (link_ev.crc_or_tmo) begin
            state_q <= EP0_ERROR;
        end else if (link_ev.status_nak) begin
            state_q <= EP0_BUSY;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign avs_readdata          = rdata_q;
    assign avs_waitrequest       = wait_q;
    assign nak_irq               = nak_irq_q;
    assign ep0_max_pkt           = max_pkt_q;
    assign zero_len_send_pending = zlp_q;
    assign ep0_wr_allow          = allow_q;
    assign ep0_toggle            = toggle_q[0];

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    logic [7:0] nak_ev_w;
    assign nak_ev_w = link_ev.nak_ep & 8'hfe;

    a_irq_blocked: assert property (@(posedge sys_clk) disable iff (!rst_n)
        ((nak_flags & ~nak_mask_q) == 8'h00) |=> !nak_irq_q)
        else $error("nak irq raised by masked or absent flag");

    a_irq_forward: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (|(nak_flags & ~nak_mask_q)) |=> nak_irq_q)
        else $error("unmasked nak flag did not raise irq");

    a_flag_masked_set: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (nak_ev_w != 8'h00) |=> ((nak_flags & $past(nak_ev_w)) == $past(nak_ev_w)))
        else $error("nak flag not set after nak sent");

    a_zlp_cmd_set: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (cmd_wr && avs_writedata[7:0] == CMD_ZERO_LEN_SEND) |=> zlp_q)
        else $error("zero-length pending not set by command");

    a_zlp_sent_clr: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (link_ev.zlp_sent && !cmd_wr) |=> !zlp_q)
        else $error("zero-length pending not cleared after send");

    a_setup_dset_clr: assert property (@(posedge sys_clk) disable iff (!rst_n)
        link_ev.setup_token |=> !dset_q)
        else $error("buffer valid survived setup");

    a_setup_lock_set: assert property (@(posedge sys_clk) disable iff (!rst_n)
        link_ev.setup_token |=> (lock_q && !ep0_wr_allow && toggle_q == 2'b00))
        else $error("setup did not lock buffer writes");

    a_setup_state_rdy: assert property (@(posedge sys_clk) disable iff (!rst_n)
        link_ev.setup_token |=> (state_q == EP0_READY))
        else $error("setup did not return state to ready");

    a_maxpkt_write: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (wr_take && lo_byte && avs_address == OFS_EP0_PKTSIZE)
        |=> (ep0_max_pkt == $past(avs_writedata[6:0])))
        else $error("max packet size write lost");

endmodule

// file: include/uenm_pkg.sv
// package for the endpoint-0 control and nak-mask block
// assumes a single 250 mhz controller clock and a 32-bit avalon-mm register port
package uenm_pkg;

    // ------------------------------------------------------------
    // register map (word-aligned byte offsets)
    // ------------------------------------------------------------
    localparam logic [4:0] OFS_NAK_FLAGS   = 5'h00;
    localparam logic [4:0] OFS_NAK_MASK    = 5'h04;
    localparam logic [4:0] OFS_EP0_PKTSIZE = 5'h08;
    localparam logic [4:0] OFS_EP0_STATE   = 5'h0c;
    localparam logic [4:0] OFS_COMMAND     = 5'h10;

    // ------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------
    localparam int NAK_EP_LO      = 1;      // endpoints 1..7 in bits 7:1
    localparam int NAK_EP_HI      = 7;
    localparam int MAXPKT_HI      = 6;      // max packet size in bits 6:0
    localparam int ZLP_PEND_BIT   = 15;
    localparam int BUF_VALID_BIT  = 12;
    localparam int WR_LOCK_BIT    = 15;
    localparam int TOGGLE_LO      = 12;     // toggle in bits 13:12
    localparam int STATE_LO       = 9;      // state in bits 11:9
    localparam logic [7:0] NAK_MASK_RST  = 8'h00;
    localparam logic [6:0] MAXPKT_RST    = 7'h00;
    localparam logic [1:0] TOGGLE_RST    = 2'h0;

    // ------------------------------------------------------------
    // command codes written to the command register, bits 7:0
    // ------------------------------------------------------------
    localparam logic [7:0] CMD_ZERO_LEN_SEND = 8'h01;
    localparam logic [7:0] CMD_SETUP_ACK     = 8'h02;

    // endpoint-0 transfer state
    typedef enum logic [2:0] {
        EP0_READY = 3'b000,
        EP0_BUSY  = 3'b001,
        EP0_ERROR = 3'b010,
        EP0_STALL = 3'b011
    } uenm_ep0_state_type;

    // one-cycle event pulses from the packet engine, same clock
    typedef struct packed {
        logic       setup_token;   // setup token received
        logic [7:0] nak_ep;        // nak sent, one bit per endpoint (bit 0 unused)
        logic       zlp_sent;      // endpoint-0 zero-length packet went out
        logic       buf_fill;      // endpoint-0 buffer now holds valid data
        logic       buf_drain;     // endpoint-0 buffer emptied
        logic       data_ack;      // endpoint-0 data phase completed, flips toggle
        logic       status_nak;    // nak returned in the status stage
        logic       crc_or_tmo;    // crc error on receive or timeout after transmit
        logic       over_len;      // host asked for more than the request length
    } uenm_link_ev_type;

endpackage

// file: hw/uenm_flag_bank.sv
// sticky nak-sent flags for endpoints 1..7
// assumes set and clear pulses arrive on the same clock; set beats clear
`timescale 1ns/100ps
module uenm_flag_bank
    import uenm_pkg::*;
(
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // set and clear strobes
    input  wire logic [7:0] set_bits,
    input  wire logic [7:0] clr_bits,
    // flag state
    output logic [7:0]      flags
);

    // ------------------------------------------------------------
    // one sticky flop per endpoint 1..7
    // ------------------------------------------------------------
    assign flags[0] = 1'b0;     // endpoint 0 has no flag here

    for (genvar i = NAK_EP_LO; i <= NAK_EP_HI; i++) begin : g_flag
        logic flag_q;
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                flag_q <= 1'b0;
            end else if (set_bits[i]) begin
                flag_q <= 1'b1;     // a nak in the clear cycle is not lost
            end else if (clr_bits[i]) begin
                flag_q <= 1'b0;
            end
        end
        assign flags[i] = flag_q;
    end

endmodule

// file: testbench/uenm_host_model.sv
// model of the upstream host as seen through the packet engine event pulses
// assumes callers enter pulse right after a rising edge of clk
`timescale 1ns/100ps
module uenm_host_model
    import uenm_pkg::*;
(
    // clock
    input  wire logic        clk,
    // events toward the block
    output uenm_link_ev_type link_ev
);
    // ------------------------------------------------------------
    // event generation
    // ------------------------------------------------------------
    // quiet bus until the first token
    initial link_ev = '0;

    // host traffic events
    // one-cycle pulse, then a quiet cycle so two calls never touch one time step
    task automatic pulse(input uenm_link_ev_type e);
        link_ev <= e;
        @(posedge clk);
        link_ev <= '0;
        @(posedge clk);
    endtask
endmodule

// file: testbench/tb.sv
// self-checking bench for the endpoint-0 control and nak-mask block
// assumes a one-wait-cycle avalon slave and one-cycle event pulses
`timescale 1ns/100ps
module tb
    import uenm_pkg::*;
;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic             sys_clk        = 1'b0;
    logic             nrst           = 1'b0;
    logic [4:0]       avs_address    = 5'h00;
    logic             avs_read       = 1'b0;
    logic             avs_write      = 1'b0;
    logic [31:0]      avs_writedata  = 32'h0;
    logic [3:0]       avs_byteenable = 4'hf;
    logic [31:0]      avs_readdata;
    logic             avs_waitrequest;
    uenm_link_ev_type link_ev;
    logic             nak_irq;
    logic [6:0]       ep0_max_pkt;
    logic             zero_len_send_pending;
    logic             ep0_wr_allow;
    logic             ep0_toggle;
    int               n_mismatch     = 0;
    int               total_checks   = 0;
    int               cyc_cnt        = 0;

    // 250 mhz clock
    always #2 sys_clk = ~sys_clk;

    uenm_ep0_ctrl dut (
        .sys_clk(sys_clk), .nrst(nrst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .link_ev(link_ev), .nak_irq(nak_irq),
        .ep0_max_pkt(ep0_max_pkt), .zero_len_send_pending(zero_len_send_pending),
        .ep0_wr_allow(ep0_wr_allow), .ep0_toggle(ep0_toggle));

    uenm_host_model host (.clk(sys_clk), .link_ev(link_ev));

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // request held until waitrequest is sampled low, released at that same edge, then one idle edge
    task automatic bus(input logic we, input logic [4:0] a, input logic [31:0] d,
                       input logic [3:0] be, output logic [31:0] q);
        avs_address    <= a;
        avs_writedata  <= d;
        avs_byteenable <= be;
        avs_write      <= we;
        avs_read       <= ~we;
        @(posedge sys_clk);
        while (avs_waitrequest !== 1'b0) begin
            @(posedge sys_clk);
        end
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
        @(posedge sys_clk);
    endtask

    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, 4'hf, q);
    endtask

    task automatic rd(input logic [4:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, 4'hf, q);
        chk(q, e);
    endtask

    // outputs are looked at mid-cycle, where they are settled
    task automatic pin(input logic [31:0] g_unused, input logic [31:0] e, input int w);
        @(negedge sys_clk);
        case (w)
            0: chk({31'h0, nak_irq}, e);
            1: chk({31'h0, zero_len_send_pending}, e);
            2: chk({31'h0, ep0_wr_allow}, e);
            3: chk({31'h0, ep0_toggle}, e);
            default: chk({25'h0, ep0_max_pkt}, e);
        endcase
        @(posedge sys_clk);
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        rd(OFS_NAK_MASK, 32'h0);
        rd(OFS_EP0_PKTSIZE, 32'h0);
        rd(OFS_EP0_STATE, 32'h0);
        pin(0, 32'h1, 2);
        pin(0, 32'h0, 0);
        $display("test reset done");
    endtask

    task automatic t_mask();
        wr(OFS_NAK_MASK, 32'hfe);
        host.pulse('{nak_ep: 8'hff, default: '0});
        pin(0, 32'h0, 0);
        rd(OFS_NAK_FLAGS, 32'hfe);
        for (int i = 1; i < 8; i++) begin
            wr(OFS_NAK_MASK, 32'hfe ^ (32'h1 << i));
            pin(0, 32'h1, 0);
            wr(OFS_NAK_MASK, 32'hfe);
            pin(0, 32'h0, 0);
        end
        wr(OFS_NAK_MASK, 32'h0);
        wr(OFS_NAK_FLAGS, 32'hf6);
        pin(0, 32'h1, 0);
        rd(OFS_NAK_FLAGS, 32'h08);
        wr(OFS_NAK_FLAGS, 32'h08);
        pin(0, 32'h0, 0);
        $display("test nak mask done");
    endtask

    task automatic t_pkt();
        logic [31:0] q;
        wr(OFS_EP0_PKTSIZE, 32'h9040);
        pin(0, 32'h40, 4);
        bus(1'b1, OFS_EP0_PKTSIZE, 32'h7f, 4'he, q);
        rd(OFS_EP0_PKTSIZE, 32'h40);
        wr(OFS_COMMAND, {24'h0, CMD_ZERO_LEN_SEND});
        pin(0, 32'h1, 1);
        rd(OFS_EP0_PKTSIZE, 32'h8040);
        host.pulse('{zlp_sent: 1'b1, default: '0});
        pin(0, 32'h0, 1);
        rd(OFS_EP0_PKTSIZE, 32'h40);
        $display("test packet size done");
    endtask

    task automatic t_buf();
        host.pulse('{buf_fill: 1'b1, default: '0});
        rd(OFS_EP0_PKTSIZE, 32'h1040);
        host.pulse('{buf_drain: 1'b1, default: '0});
        rd(OFS_EP0_PKTSIZE, 32'h40);
        host.pulse('{buf_fill: 1'b1, default: '0});
        host.pulse('{setup_token: 1'b1, default: '0});
        rd(OFS_EP0_PKTSIZE, 32'h40);
        rd(OFS_EP0_STATE, 32'h8000);
        pin(0, 32'h0, 2);
        wr(OFS_COMMAND, {24'h0, CMD_SETUP_ACK});
        pin(0, 32'h1, 2);
        $display("test buffer and lock done");
    endtask

    task automatic t_state();
        host.pulse('{data_ack: 1'b1, default: '0});
        rd(OFS_EP0_STATE, 32'h1000);
        pin(0, 32'h1, 3);
        host.pulse('{status_nak: 1'b1, default: '0});
        rd(OFS_EP0_STATE, 32'h1200);
        host.pulse('{crc_or_tmo: 1'b1, default: '0});
        rd(OFS_EP0_STATE, 32'h1400);
        host.pulse('{over_len: 1'b1, default: '0});
        rd(OFS_EP0_STATE, 32'h1600);
        host.pulse('{setup_token: 1'b1, default: '0});
        rd(OFS_EP0_STATE, 32'h8000);
        wr(5'h14, 32'hffff);
        rd(5'h14, 32'h0);
        $display("test state and unmapped done");
    endtask

    // ------------------------------------------------------------
    // run control
    // ------------------------------------------------------------
    // ceiling well above the roughly 190 cycles the tests need
    always @(posedge sys_clk) begin
        cyc_cnt++;
        if (cyc_cnt == 5000) begin
            n_mismatch++;
            give_verdict();
        end
    end

    initial begin
        repeat (16) @(posedge sys_clk);
        nrst <= 1'b1;
        repeat (4) @(posedge sys_clk);
        t_reset();
        t_mask();
        t_pkt();
        t_buf();
        t_state();
        give_verdict();
    end
endmodule
